/* hw/twet_consts.vh */
// Purpose: Shared constants of the two-wire memory target.
// Assumes: Included by every design file of the block by its bare name.
// Notes:   Definitions only; no logic lives here.
`ifndef TWET_CONSTS_VH
`define TWET_CONSTS_VH

// ----------------------------------------------------------------------------
// Device address word
// ----------------------------------------------------------------------------
// Fixed memory-class pattern in the four upper bits of the device address word.
`define TWET_PREAMBLE 4'hA
// Bit that selects read (high) or write (low).
`define TWET_DIR_BIT 0
// Number of strap inputs compared with the device address word.
`define TWET_STRAP_W 3

// ----------------------------------------------------------------------------
// Word and memory layout
// ----------------------------------------------------------------------------
// Bits per transferred word.
`define TWET_WORD_BITS 4'h8
// Low address bits that step inside a page of 32 bytes.
`define TWET_PAGE_BITS 5
// Word address widths of the two variants.
`define TWET_ADDR_W_SMALL 12
`define TWET_ADDR_W_LARGE 13
// Data width of one memory word.
`define TWET_DATA_W 8

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
// Longest internal program time in microseconds.
`define TWET_PROG_TIME_US 5000
// Core clock rate in MHz.
`define TWET_CLK_MHZ 25
// Consecutive equal samples a line needs before its filtered level follows.
`define TWET_FILT_LEN 2

// ----------------------------------------------------------------------------
// Line levels and word kinds
// ----------------------------------------------------------------------------
// Level of an idle bus line.
`define TWET_LINE_IDLE 1'h1
// Kind of the word being received.
`define TWET_KIND_DEV 2'h0
`define TWET_KIND_AHI 2'h1
`define TWET_KIND_ALO 2'h2
`define TWET_KIND_DAT 2'h3

`endif

/* hw/twet_filt.v */
// Purpose: Synchroniser and glitch filter for one bus line.
// Assumes: The line is asynchronous to clk.
// Notes:   The filtered level only follows after FILT_LEN equal samples.
`timescale 1ns/1ps
`default_nettype none
`include "twet_consts.vh"

module twet_filt #(
    parameter FILT_LEN = `TWET_FILT_LEN
) (
    input wire clk,
    input wire rst_n,
    input wire pin_in,
    output reg level_out
);

    localparam CNT_W = $clog2(FILT_LEN + 1);
    localparam [CNT_W-1:0] CNT_TOP = FILT_LEN;

    reg sync1_q;
    reg sync2_q;
    reg [CNT_W-1:0] cnt_q;

    // --------------------------------------------------------------------
    // Two-stage synchroniser
    // --------------------------------------------------------------------
    // The first stage feeds only the second stage.
    always @(posedge clk) begin
        if (!rst_n) begin
            sync1_q <= `TWET_LINE_IDLE;
            sync2_q <= `TWET_LINE_IDLE;
        end else begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
        end
    end

    // --------------------------------------------------------------------
    // Glitch filter
    // --------------------------------------------------------------------
    // A differing sample must persist before the output changes.
    always @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= {CNT_W{1'h0}};
            level_out <= `TWET_LINE_IDLE;
        end else if (sync2_q == level_out) begin
            cnt_q <= {CNT_W{1'h0}};
        end else if (cnt_q == CNT_TOP - 1'h1) begin
            cnt_q <= {CNT_W{1'h0}};
            level_out <= sync2_q;
        end else begin
            cnt_q <= cnt_q + 1'h1;
        end
    end

endmodule // twet_filt
`default_nettype wire

/* hw/twet_mem.v */
// Purpose: Byte array of the memory with one write and one read port.
// Assumes: Same clock as the protocol logic.
// Notes:   Read data come from a register one cycle after the address.
`timescale 1ns/1ps
`default_nettype none
`include "twet_consts.vh"

module twet_mem #(
    parameter ADDR_W = `TWET_ADDR_W_LARGE,
    parameter DATA_W = `TWET_DATA_W
) (
    input wire clk,
    input wire rst_n,
    input wire wr_en,
    input wire [ADDR_W-1:0] wr_addr,
    input wire [DATA_W-1:0] wr_data,
    input wire [ADDR_W-1:0] rd_addr,
    output reg [DATA_W-1:0] rd_data
);

    localparam DEPTH = 1 << ADDR_W;

    reg [DATA_W-1:0] mem [0:DEPTH-1];

    // --------------------------------------------------------------------
    // Array access
    // --------------------------------------------------------------------
    // Write when asked; read every cycle into the output register.
    always @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        if (!rst_n) begin
            rd_data <= {DATA_W{1'h0}};
        end else begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule // twet_mem
`default_nettype wire

/* hw/twet_top.v */
// Purpose: Target side of a two-wire serial memory with page writes and reads.
// Assumes: Bus lines and straps are asynchronous and sampled by clk.
// Notes:   The data line is only ever pulled low; the bench resolves the wire.
`timescale 1ns/1ps
`default_nettype none
`include "twet_consts.vh"

module twet_top #(
    parameter ADDR_W = `TWET_ADDR_W_LARGE,
    parameter [31:0] PROG_CYCLES = `TWET_PROG_TIME_US * `TWET_CLK_MHZ,
    parameter FILT_LEN = `TWET_FILT_LEN
) (
    input wire clk,
    input wire rst_n,
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output wire sda_oe,
    input wire [`TWET_STRAP_W-1:0] chip_select_straps,
    input wire write_protect,
    output wire prog_busy,
    output wire standby
);

    // --------------------------------------------------------------------
    // Constants
    // --------------------------------------------------------------------
    localparam ST_IDLE = 5'h01;
    localparam ST_RX = 5'h02;
    localparam ST_ACK = 5'h04;
    localparam ST_TX = 5'h08;
    localparam ST_RACK = 5'h10;
    localparam CNT_W = $clog2(PROG_CYCLES + 1);
    localparam [CNT_W-1:0] PROG_LOAD = PROG_CYCLES[CNT_W-1:0];
    localparam PB = `TWET_PAGE_BITS;

    // --------------------------------------------------------------------
    // Functions
    // --------------------------------------------------------------------
    // Next address inside the same page.
    function [ADDR_W-1:0] page_next;
        input [ADDR_W-1:0] a;
        begin
            page_next = {a[ADDR_W-1:PB], a[PB-1:0] + 1'h1};
        end
    endfunction

    // True when a device word carries the preamble and our strap value.
    function dev_match;
        input [7:0] w;
        input [`TWET_STRAP_W-1:0] s;
        begin
            dev_match = (w[7:4] == `TWET_PREAMBLE) && (w[3:1] == s);
        end
    endfunction

    // --------------------------------------------------------------------
    // Declarations
    // --------------------------------------------------------------------
    wire [1:0] pins_raw;
    wire [1:0] pins_f;
    wire scl_f;
    wire sda_f;
    reg scl_prev_q;
    reg sda_prev_q;
    reg [`TWET_STRAP_W-1:0] straps_s1_q;
    reg [`TWET_STRAP_W-1:0] straps_s2_q;
    reg wp_s1_q;
    reg wp_s2_q;
    reg [4:0] state_q;
    reg [1:0] kind_q;
    reg [3:0] bit_cnt_q;
    reg [7:0] shift_q;
    reg [7:0] tx_q;
    reg [7:0] addr_hi_q;
    reg [ADDR_W-1:0] addr_q;
    reg rw_q;
    reg mack_q;
    reg sda_oe_q;
    reg wrote_q;
    reg [CNT_W-1:0] busy_cnt_q;
    reg wr_en_q;
    reg [ADDR_W-1:0] wr_addr_q;
    reg [7:0] wr_data_q;
    wire [7:0] rd_data;
    wire [15:0] addr_full;
    wire scl_rise;
    wire scl_fall;
    wire start_det;
    wire stop_det;
    wire byte_done;

    // --------------------------------------------------------------------
    // Line conditioning
    // --------------------------------------------------------------------
    // Both lines pass the same filter so their delays stay equal.
    assign pins_raw = {sda_in, scl_in};
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_filt
            twet_filt #(
                .FILT_LEN(FILT_LEN)
            ) u_filt (
                .clk(clk),
                .rst_n(rst_n),
                .pin_in(pins_raw[gi]),
                .level_out(pins_f[gi])
            );
        end
    endgenerate
    assign scl_f = pins_f[0];
    assign sda_f = pins_f[1];

    // Straps and protect input are pins, so they are synchronised too.
    always @(posedge clk) begin
        if (!rst_n) begin
            straps_s1_q <= {`TWET_STRAP_W{1'h0}};
            straps_s2_q <= {`TWET_STRAP_W{1'h0}};
            wp_s1_q <= 1'h1;
            wp_s2_q <= 1'h1;
        end else begin
            straps_s1_q <= chip_select_straps;
            straps_s2_q <= straps_s1_q;
            wp_s1_q <= write_protect;
            wp_s2_q <= wp_s1_q;
        end
    end

    // Previous filtered levels for edge detection.
    always @(posedge clk) begin
        if (!rst_n) begin
            scl_prev_q <= `TWET_LINE_IDLE;
            sda_prev_q <= `TWET_LINE_IDLE;
        end else begin
            scl_prev_q <= scl_f;
            sda_prev_q <= sda_f;
        end
    end

    // --------------------------------------------------------------------
    // Bus events
    // --------------------------------------------------------------------
    // Data edges with the clock high both before and now are conditions.
    assign scl_rise = scl_f & ~scl_prev_q;
    assign scl_fall = ~scl_f & scl_prev_q;
    assign start_det = scl_f & scl_prev_q & sda_prev_q & ~sda_f;
    assign stop_det = scl_f & scl_prev_q & ~sda_prev_q & sda_f;
    assign byte_done = scl_fall && (bit_cnt_q == `TWET_WORD_BITS);
    assign addr_full = {addr_hi_q, shift_q};

    // --------------------------------------------------------------------
    // Protocol engine
    // --------------------------------------------------------------------
    // Receives words, acknowledges them, writes the array and sends data.
    always @(posedge clk) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            kind_q <= `TWET_KIND_DEV;
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
            tx_q <= 8'h00;
            addr_hi_q <= 8'h00;
            addr_q <= {ADDR_W{1'h0}};
            rw_q <= 1'h0;
            mack_q <= 1'h0;
            sda_oe_q <= 1'h0;
            wrote_q <= 1'h0;
            busy_cnt_q <= {CNT_W{1'h0}};
            wr_en_q <= 1'h0;
            wr_addr_q <= {ADDR_W{1'h0}};
            wr_data_q <= 8'h00;
        end else begin
            wr_en_q <= 1'h0;
            // Program timer runs down independently of the bus.
            if (busy_cnt_q != {CNT_W{1'h0}}) begin
                busy_cnt_q <= busy_cnt_q - 1'h1;
            end
            if (stop_det) begin
                // Stop ends any sequence; a finished write starts programming.
                state_q <= ST_IDLE;
                sda_oe_q <= 1'h0;
                if (wrote_q) begin
                    busy_cnt_q <= PROG_LOAD;
                    wrote_q <= 1'h0;
                end
            end else if (start_det) begin
                // Every command begins with the device word after a start.
                state_q <= ST_RX;
                kind_q <= `TWET_KIND_DEV;
                bit_cnt_q <= 4'h0;
                sda_oe_q <= 1'h0;
            end else begin
                case (state_q)
                    ST_RX: begin
                        if (scl_rise) begin
                            // The master only moves data while clock is low.
                            shift_q <= {shift_q[6:0], sda_f};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end else if (byte_done) begin
                            bit_cnt_q <= 4'h0;
                            state_q <= ST_ACK;
                            sda_oe_q <= 1'h1;
                            case (kind_q)
                                `TWET_KIND_DEV: begin
                                    if (dev_match(shift_q, straps_s2_q) &&
                                        (busy_cnt_q == {CNT_W{1'h0}})) begin
                                        rw_q <= shift_q[`TWET_DIR_BIT];
                                    end else begin
                                        // Wrong address or still programming.
                                        state_q <= ST_IDLE;
                                        sda_oe_q <= 1'h0;
                                    end
                                end
                                `TWET_KIND_AHI: begin
                                    addr_hi_q <= shift_q;
                                end
                                `TWET_KIND_ALO: begin
                                    addr_q <= addr_full[ADDR_W-1:0];
                                end
                                default: begin
                                    // Data word: store unless protected.
                                    wr_en_q <= ~wp_s2_q;
                                    wr_addr_q <= addr_q;
                                    wr_data_q <= shift_q;
                                    if (!wp_s2_q) begin
                                        wrote_q <= 1'h1;
                                    end
                                    addr_q <= page_next(addr_q);
                                end
                            endcase
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            // End of the ninth clock: release, then go on.
                            sda_oe_q <= 1'h0;
                            state_q <= ST_RX;
                            if ((kind_q == `TWET_KIND_DEV) && rw_q) begin
                                // Read starts at the address counter.
                                state_q <= ST_TX;
                                tx_q <= {rd_data[6:0], 1'h0};
                                sda_oe_q <= ~rd_data[7];
                                bit_cnt_q <= 4'h1;
                            end else if (kind_q != `TWET_KIND_DAT) begin
                                kind_q <= kind_q + 2'h1;
                            end
                        end
                    end
                    ST_TX: begin
                        if (scl_fall) begin
                            if (bit_cnt_q == `TWET_WORD_BITS) begin
                                // Release for the master acknowledge.
                                sda_oe_q <= 1'h0;
                                state_q <= ST_RACK;
                                addr_q <= addr_q + 1'h1;
                            end else begin
                                sda_oe_q <= ~tx_q[7];
                                tx_q <= {tx_q[6:0], 1'h0};
                                bit_cnt_q <= bit_cnt_q + 4'h1;
                            end
                        end
                    end
                    ST_RACK: begin
                        if (scl_rise) begin
                            mack_q <= ~sda_f;
                        end else if (scl_fall) begin
                            if (mack_q) begin
                                // Acknowledged: send the next word.
                                state_q <= ST_TX;
                                tx_q <= {rd_data[6:0], 1'h0};
                                sda_oe_q <= ~rd_data[7];
                                bit_cnt_q <= 4'h1;
                            end else begin
                                // No acknowledge: wait for the stop.
                                state_q <= ST_IDLE;
                            end
                        end
                    end
                    default: begin
                        state_q <= ST_IDLE;
                        sda_oe_q <= 1'h0;
                    end
                endcase
            end
        end
    end

    // --------------------------------------------------------------------
    // Storage
    // --------------------------------------------------------------------
    // Read port always follows the address counter.
    twet_mem #(
        .ADDR_W(ADDR_W),
        .DATA_W(`TWET_DATA_W)
    ) u_mem (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(wr_en_q),
        .wr_addr(wr_addr_q),
        .wr_data(wr_data_q),
        .rd_addr(addr_q),
        .rd_data(rd_data)
    );

    // --------------------------------------------------------------------
    // Outputs
    // --------------------------------------------------------------------
    // The data line is never driven high.
    assign sda_out = 1'h0;
    assign sda_oe = sda_oe_q;
    assign prog_busy = (busy_cnt_q != {CNT_W{1'h0}});
    assign standby = (state_q == ST_IDLE) && !prog_busy;

endmodule // twet_top
`default_nettype wire

/* testbench/twet_master.sv */
// Purpose: Bus master model for the two-wire memory target.
// Assumes: The bench holds the data wire high through a pull-up.
// Notes:   A bit lasts 320 ns: 240 ns clock low, then 80 ns high.
`timescale 1ns/1ps
`default_nettype none
module twet_master (
    input wire logic clk,
    input wire logic sda,
    output var logic scl,
    output var logic pull
);
    // ----------------
    // Bus tasks
    // ----------------
    // The bus starts idle with both lines high.
    initial begin
        scl = 1'b1;
        pull = 1'b0;
    end
    // Sets data in the low phase and samples the wire at the end of high.
    task automatic bit_io(input logic b, output logic r);
        scl <= 1'b0;
        #80 pull <= !b;
        #160 scl <= 1'b1;
        #80 r = sda;
    endtask
    // Data falls with clock high; every change is a non-blocking update on a clk edge.
    task automatic start();
        @(posedge clk);
        scl <= 1'b0;
        #80 pull <= 1'b0;
        #160 scl <= 1'b1;
        #160 pull <= 1'b1;
        #160;
    endtask
    // Data rises with clock high.
    task automatic stop();
        @(posedge clk);
        scl <= 1'b0;
        #80 pull <= 1'b1;
        #160 scl <= 1'b1;
        #160 pull <= 1'b0;
        #160;
    endtask
    // Sends a byte, highest bit first, and returns the acknowledge.
    task automatic send(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], r);
        end
        bit_io(1'b1, r);
        ack = !r;
    endtask
    // Receives a byte and acknowledges it when more are wanted.
    task automatic recv(output logic [7:0] b, input logic more);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            b[i] = r;
        end
        bit_io(!more, r);
    endtask
    // Clocks at most nine times until the wire reads high in a high phase.
    task automatic recover(output logic freed);
        freed = 1'b0;
        for (int i = 0; i < 9 && !freed; i++) begin
            bit_io(1'b1, freed);
        end
    endtask
endmodule // twet_master
`default_nettype wire

/* testbench/twet_top_checker.sv */
// Purpose: Assertions on the ports of the two-wire memory target.
// Assumes: Bus pins are sampled by clk, as the design samples them.
// Notes:   The program time is checked against PROG_CYCLES.
`timescale 1ns/1ps
`default_nettype none
module twet_top_checker #(
    parameter [31:0] PROG_CYCLES = 32'h1E848
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic write_protect,
    input wire logic prog_busy,
    input wire logic standby
);
    // ----------------
    // Helpers
    // ----------------
    logic [31:0] busy_q;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // Counts the cycles of the running program time.
    always @(posedge clk) begin
        if (!rst_n || !prog_busy) begin
            busy_q <= 32'h0;
        end else begin
            busy_q <= busy_q + 32'h1;
        end
    end
    // Start and stop as they appear on the pins.
    sequence s_start;
        scl_in && $past(scl_in) && $fell(sda_in);
    endsequence
    sequence s_stop;
        scl_in && $past(scl_in) && $rose(sda_in);
    endsequence
    // ----------------
    // Properties
    // ----------------
    property p_oe_low;
        $changed(sda_oe) |-> !scl_in;
    endproperty
    a_oe_low: assert property (p_oe_low)
        else $error("data pull changed while clock high");
    property p_pull_only;
        !sda_out;
    endproperty
    a_pull_only: assert property (p_pull_only)
        else $error("data line driven high");
    property p_busy_len;
        $fell(prog_busy) |-> busy_q == PROG_CYCLES;
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("program time has wrong length");
    property p_busy_deaf;
        prog_busy |-> !sda_oe;
    endproperty
    a_busy_deaf: assert property (p_busy_deaf)
        else $error("acknowledge during program time");
    property p_start_wake;
        s_start |-> ##[1:8] !standby;
    endproperty
    a_start_wake: assert property (p_start_wake)
        else $error("still in standby after start");
    property p_wp_block;
        $rose(prog_busy) |-> !write_protect;
    endproperty
    a_wp_block: assert property (p_wp_block)
        else $error("program started while protected");
    property p_stop_idle;
        s_stop |-> ##[1:12] (standby || prog_busy);
    endproperty
    a_stop_idle: assert property (p_stop_idle)
        else $error("no standby after stop");
    property p_start_quiet;
        s_start |-> !sda_oe [*8];
    endproperty
    a_start_quiet: assert property (p_start_quiet)
        else $error("data pulled right after start");
    property p_reset_idle;
        $rose(rst_n) |-> standby && !sda_oe && !prog_busy;
    endproperty
    a_reset_idle: assert property (p_reset_idle)
        else $error("not idle after reset");
endmodule // twet_top_checker
bind twet_top twet_top_checker #(.PROG_CYCLES(PROG_CYCLES)) i_twet_top_checker (
    .clk(clk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .write_protect(write_protect), .prog_busy(prog_busy),
    .standby(standby));
`default_nettype wire

/* testbench/twet_top_tb.sv */
// Purpose: Self-checking bench of the two-wire memory target.
// Assumes: A pull-up holds the data wire high when nobody pulls.
// Notes:   The program time is cut to 200 cycles.
`timescale 1ns/1ps
`default_nettype none
module twet_top_tb;
    // ----------------
    // Clock and wiring
    // ----------------
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] straps = 3'h5;
    logic wp = 1'b0;
    logic scl;
    logic pull;
    wire sda_oe;
    wire prog_busy;
    wire standby;
    int n_mismatch = 0;
    int checked = 0;
    int cyc = 0;
    // Resolves the open-drain data wire against its pull-up.
    wire sda = !(pull || sda_oe);
    // Makes the 25 MHz core clock.
    always #20 clk = !clk;
    twet_top #(.PROG_CYCLES(200), .FILT_LEN(1)) i_twet_top (.clk(clk), .rst_n(rst_n),
        .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
        .chip_select_straps(straps), .write_protect(wp), .prog_busy(prog_busy),
        .standby(standby));
    twet_master i_twet_master (.clk(clk), .sda(sda), .scl(scl), .pull(pull));
    // Cuts a hung run short.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    // ----------------
    // Shared tasks
    // ----------------
    // Compares one byte-wide result.
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Start, then the device word with the given direction.
    task automatic dev(input logic rw, output logic ack);
        i_twet_master.start();
        i_twet_master.send({4'hA, straps, rw}, ack);
    endtask
    // Opens a write and loads the word address.
    task automatic set_addr(input logic [15:0] a);
        logic ack;
        dev(1'b0, ack);
        chk("device ack", 8'h01, {7'h0, ack});
        i_twet_master.send(a[15:8], ack);
        chk("high address ack", 8'h01, {7'h0, ack});
        i_twet_master.send(a[7:0], ack);
        chk("low address ack", 8'h01, {7'h0, ack});
    endtask
    // Writes n bytes counting up from d0.
    task automatic wr(input logic [15:0] a, input logic [7:0] d0, input int n);
        logic ack;
        set_addr(a);
        for (int i = 0; i < n; i++) begin
            i_twet_master.send(d0 + 8'(i), ack);
            chk("data ack", 8'h01, {7'h0, ack});
        end
        i_twet_master.stop();
    endtask
    // Polls until the program time is over.
    task automatic poll();
        logic ack;
        ack = 1'b0;
        for (int k = 0; k < 20 && !ack; k++) begin
            dev(1'b0, ack);
            i_twet_master.stop();
            if (k == 0) chk("busy poll", 8'h00, {7'h0, ack});
        end
        chk("poll ack", 8'h01, {7'h0, ack});
        #410 chk("standby", 8'h01, {7'h0, standby});
    endtask
    // Random read of n bytes expected to count up from e0.
    task automatic rd(input logic [15:0] a, input int n, input logic [7:0] e0);
        logic ack;
        logic [7:0] b;
        set_addr(a);
        dev(1'b1, ack);
        chk("read ack", 8'h01, {7'h0, ack});
        for (int i = 0; i < n; i++) begin
            i_twet_master.recv(b, i < n - 1);
            chk("read data", e0 + 8'(i), b);
        end
        i_twet_master.stop();
    endtask
    // ----------------
    // Scenarios
    // ----------------
    // Every strap code and a wrong preamble.
    task automatic test_straps();
        logic ack;
        for (int k = 0; k < 8; k++) begin
            i_twet_master.start();
            i_twet_master.send({4'hA, 3'(k), 1'b0}, ack);
            i_twet_master.stop();
            chk("strap match", {7'h0, 3'(k) == straps}, {7'h0, ack});
        end
        i_twet_master.start();
        i_twet_master.send({4'h5, straps, 1'b0}, ack);
        i_twet_master.stop();
        chk("preamble", 8'h00, {7'h0, ack});
        $display("strap test done");
    endtask
    // 34 bytes from offset 30 wrap once inside page 0.
    task automatic test_page();
        wr(16'h001E, 8'h00, 34);
        poll();
        rd(16'h0000, 32, 8'h02);
        $display("page write test done");
    endtask
    // Reads across the top of the array, then from the counter.
    task automatic test_wrap();
        logic ack;
        logic [7:0] b;
        wr(16'h1FFF, 8'h01, 1);
        poll();
        rd(16'h1FFF, 3, 8'h01);
        dev(1'b1, ack);
        i_twet_master.recv(b, 1'b0);
        i_twet_master.stop();
        chk("current read", 8'h04, b);
        set_addr(16'h1FFF);
        dev(1'b1, ack);
        i_twet_master.recover(ack);
        chk("wire freed", 8'h01, {7'h0, ack});
        rd(16'h0000, 1, 8'h02);
        $display("wrap read test done");
    endtask
    // A protected write is acknowledged but leaves the array alone.
    task automatic test_protect();
        @(posedge clk) wp <= 1'b1;
        repeat (4) @(posedge clk);
        wr(16'h0005, 8'hEE, 1);
        #810 chk("protect busy", 8'h00, {7'h0, prog_busy});
        @(posedge clk) wp <= 1'b0;
        repeat (4) @(posedge clk);
        rd(16'h0005, 1, 8'h07);
        $display("protect test done");
    endtask
    // Resets the block, then runs every scenario.
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        #1 chk("reset standby", 8'h01, {7'h0, standby});
        test_straps();
        test_page();
        test_wrap();
        test_protect();
        print_verdict();
    end
endmodule // twet_top_tb
`default_nettype wire
